// [pkg/dett_map.svh]
// Purpose: register offsets, field positions, codes and reset values of the trace unit
// Assumes: APB with 32-bit data, byte addresses on aligned words
// Notes: definitions only
`ifndef DETT_MAP_SVH
`define DETT_MAP_SVH
// register offsets
`define DETT_OFF_CTRL 8'h00
`define DETT_OFF_EVADDR 8'h04
`define DETT_OFF_AMASK 8'h08
`define DETT_OFF_EVDATA 8'h0C
`define DETT_OFF_DMASK 8'h10
`define DETT_OFF_STATUS 8'h14
`define DETT_OFF_ISTAT 8'h18
`define DETT_OFF_IMASK 8'h1C
`define DETT_OFF_INDEX 8'h20
`define DETT_OFF_TADDR 8'h24
`define DETT_OFF_TDATA 8'h28
`define DETT_OFF_CMD 8'h2C
// control fields
`define DETT_CTRL_W 11
`define DETT_CTRL_RST 11'h000
`define DETT_C_EN 0
`define DETT_C_SZ 2:1
`define DETT_C_TY 4:3
`define DETT_C_DATA 5
`define DETT_C_STEV 6
`define DETT_C_SP 8:7
`define DETT_C_BKEV 9
`define DETT_C_BKFULL 10
// field codes
`define DETT_SZ_ANY 2'h0
`define DETT_SZ_BYTE 2'h1
`define DETT_SZ_WORD 2'h2
`define DETT_TY_RW 2'h0
`define DETT_TY_RD 2'h1
`define DETT_TY_WR 2'h2
`define DETT_SP_BREAK 2'h0
`define DETT_SP_FULL 2'h1
`define DETT_SP_EVENT 2'h2
// address mask bit count width
`define DETT_AMW 5
// interrupt bits
`define DETT_IRQ_W 3
`define DETT_I_MATCH 0
`define DETT_I_STOP 1
`define DETT_I_FULL 2
// status and entry fields
`define DETT_S_RUN 0
`define DETT_S_STOP 1
`define DETT_S_VIS 2
`define DETT_S_FULL 3
`define DETT_S_CNT 16
`define DETT_T_IP 16
`define DETT_T_TYPE 16
`define DETT_T_EMUL 17
`define DETT_CMD_CLR 0
`endif

// [pkg/dett_pkg.sv]
// Purpose: shared types of the trace unit
// Assumes: nothing
// Notes: constants live in dett_map.svh
package dett_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_STOP} dett_state_e;
    typedef logic [31:0] dett_word_t;
endpackage

// [pkg/dett_cmp_if.sv]
// Purpose: event settings and access sample between the top and the comparator
// Assumes: one clock, comparator is combinational
// Notes: hit answers in the same cycle as the access
`timescale 1ns/1ps
`include "dett_map.svh"
interface dett_cmp_if #(parameter int AW = 16, parameter int DW = 16);
    logic en;
    logic [1:0] size;
    logic [1:0] acc_type;
    logic [AW-1:0] ev_addr;
    logic [`DETT_AMW-1:0] amask_bits;
    logic [DW-1:0] ev_data;
    logic [DW-1:0] dmask;
    logic valid;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic word;
    logic write;
    logic hit;
    modport cfg (output en, size, acc_type, ev_addr, amask_bits, ev_data, dmask,
        output valid, addr, data, word, write, input hit);
    modport cmp (input en, size, acc_type, ev_addr, amask_bits, ev_data, dmask,
        input valid, addr, data, word, write, output hit);
endinterface

// [hdl/dett_match.sv]
// Purpose: event comparator for one access of the core
// Assumes: settings are stable while accesses are compared
// Notes: purely combinational, no state
`timescale 1ns/1ps
`include "dett_map.svh"
module dett_match #(parameter int AW = 16, parameter int DW = 16) (
    // settings and access
    dett_cmp_if.cmp c
);
    logic [AW-1:0] amask;
    logic [DW-1:0] dmask_eff;
    logic [DW-1:0] full_mask;
    logic size_ok;
    logic type_ok;
    logic both_masked;

    // byte events compare only the low data byte
    always_comb begin
        amask = ~((AW'(1) << c.amask_bits) - AW'(1));
        full_mask = (c.size == `DETT_SZ_BYTE) ? DW'(8'hFF) : {DW{1'b1}};
        dmask_eff = c.dmask & full_mask;
        // odd-address word accesses look byte wide to the comparator
        case (c.size)
            `DETT_SZ_BYTE: size_ok = ~c.word | c.addr[0];
            `DETT_SZ_WORD: size_ok = c.word & ~c.addr[0];
            default: size_ok = 1'b1;
        endcase
        case (c.acc_type)
            `DETT_TY_RD: type_ok = ~c.write;
            `DETT_TY_WR: type_ok = c.write;
            default: type_ok = 1'b1;
        endcase
        // partial masks on both sides cannot be honoured together
        both_masked = (c.amask_bits != '0) && (dmask_eff != '0)
            && (dmask_eff != full_mask);
        c.hit = c.en & c.valid & size_ok & type_ok & ~both_masked
            & (((c.addr ^ c.ev_addr) & amask) == '0)
            & (((c.data ^ c.ev_data) & dmask_eff) == '0);
    end
endmodule

// [hdl/dett_top.sv]
// Purpose: debug event comparator and trace recorder with an APB register file
// Assumes: core access and branch strobes are on pclk; DEPTH is a power of two
// Notes: trace entries read back through INDEX, TADDR and TDATA
//
// Overview of operation
// - newest entry at trace end is index zero
// - branch entries: source/destination, address, no data
// - data entries: read/write, data, event address
// - byte size matches byte accesses, any address
// - word size matches word accesses, even address
// - access type gates read, write or both
// - starting event access itself is not recorded
// - simultaneous start and stop ignores the stop
// - non-break stop shows trace after halt
// - address mask and partial data mask together never match
// - emulator area accesses marked in entries
// - wrong access size never matches, save odd-address word accesses on byte size
`timescale 1ns/1ps
`include "dett_map.svh"
module dett_top #(
    parameter int AW = 16,
    parameter int DW = 16,
    parameter int DEPTH = 64,
    parameter int IW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core data accesses
    input wire logic acc_valid,
    input wire logic [AW-1:0] acc_addr,
    input wire logic [DW-1:0] acc_data,
    input wire logic acc_word,
    input wire logic acc_write,
    input wire logic [AW-1:0] acc_ip,
    input wire logic acc_emul,
    // core branches
    input wire logic br_valid,
    input wire logic br_dest,
    input wire logic [AW-1:0] br_addr,
    input wire logic br_emul,
    // program control
    input wire logic prog_go,
    input wire logic prog_running,
    // to core and cpu
    output logic break_req,
    output logic irq
);
    dett_cmp_if #(.AW(AW), .DW(DW)) cmp_bus ();
    dett_match #(.AW(AW), .DW(DW)) u_match (.c(cmp_bus));

    // registers
    logic [`DETT_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [AW-1:0] evaddr_r, evaddr_nxt;
    logic [`DETT_AMW-1:0] amask_r, amask_nxt;
    logic [DW-1:0] evdata_r, evdata_nxt, dmask_r, dmask_nxt;
    logic [`DETT_IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt;
    logic [IW:0] idx_r, idx_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    // trace state
    dett_pkg::dett_state_e st_r, st_nxt;
    logic [IW:0] cnt_r, cnt_nxt;
    logic [IW-1:0] wp_r, wp_nxt;
    logic run_q_r, brk_r, brk_nxt, irq_r, irq_nxt;
    // trace memory
    logic [AW-1:0] m_addr [DEPTH];
    logic [AW-1:0] m_ip [DEPTH];
    logic [DW-1:0] m_data [DEPTH];
    logic m_type [DEPTH];
    logic m_emul [DEPTH];
    // decode and helpers
    logic wr_en, clr_cmd, hit, halt_p, full, vis, rec, start_hit, stop_hit;
    logic ent_ok;
    logic [IW-1:0] rloc;
    logic [`DETT_IRQ_W-1:0] ev;
    logic [AW-1:0] range_base;
    dett_pkg::dett_word_t rd_val;

    // comparator wiring
    assign cmp_bus.en = ctrl_r[`DETT_C_EN];
    assign cmp_bus.size = ctrl_r[`DETT_C_SZ];
    assign cmp_bus.acc_type = ctrl_r[`DETT_C_TY];
    assign cmp_bus.ev_addr = evaddr_r;
    assign cmp_bus.amask_bits = amask_r;
    assign cmp_bus.ev_data = evdata_r;
    assign cmp_bus.dmask = dmask_r;
    assign cmp_bus.valid = acc_valid;
    assign cmp_bus.addr = acc_addr;
    assign cmp_bus.data = acc_data;
    assign cmp_bus.word = acc_word;
    assign cmp_bus.write = acc_write;
    assign hit = cmp_bus.hit;

    // status helpers; a break is the falling edge of the running level
    assign halt_p = run_q_r & ~prog_running;
    assign full = (cnt_r == (IW+1)'(DEPTH));
    assign vis = (st_r == dett_pkg::ST_STOP) & ~prog_running;
    assign rloc = wp_r - IW'(1) - idx_r[IW-1:0];
    assign ent_ok = vis & (idx_r < cnt_r);
    assign range_base = evaddr_r & ~((AW'(1) << amask_r) - AW'(1));
    assign wr_en = psel & penable & pwrite & pready_r;
    assign clr_cmd = wr_en & (paddr == `DETT_OFF_CMD) & pwdata[`DETT_CMD_CLR];

    // trace sequencing
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        wp_nxt = wp_r;
        rec = 1'b0;
        start_hit = ctrl_r[`DETT_C_STEV] & hit;
        stop_hit = ((ctrl_r[`DETT_C_SP] == `DETT_SP_BREAK) & halt_p)
            | ((ctrl_r[`DETT_C_SP] == `DETT_SP_FULL) & full)
            | ((ctrl_r[`DETT_C_SP] == `DETT_SP_EVENT) & hit);
        case (st_r)
            dett_pkg::ST_ARMED: begin
                if (hit) begin
                    st_nxt = dett_pkg::ST_RUN;
                end
            end
            dett_pkg::ST_RUN: begin
                // wrap keeps newest entries unless a full stop is set
                rec = (ctrl_r[`DETT_C_DATA] ? hit : br_valid)
                    & ~((ctrl_r[`DETT_C_SP] == `DETT_SP_FULL) & full);
                if (stop_hit && !start_hit) begin
                    st_nxt = dett_pkg::ST_STOP;
                end
            end
            dett_pkg::ST_IDLE: ;
            dett_pkg::ST_STOP: ;
            default: st_nxt = dett_pkg::ST_IDLE;
        endcase
        if (rec) begin
            wp_nxt = wp_r + IW'(1);
            cnt_nxt = full ? cnt_r : cnt_r + (IW+1)'(1);
        end
        // program launch restarts; an event start waits for its trigger
        if (prog_go) begin
            st_nxt = ctrl_r[`DETT_C_STEV] ? dett_pkg::ST_ARMED : dett_pkg::ST_RUN;
            rec = 1'b0;
            cnt_nxt = '0;
            wp_nxt = '0;
        end
        if (clr_cmd) begin
            st_nxt = dett_pkg::ST_IDLE;
            rec = 1'b0;
            cnt_nxt = '0;
            wp_nxt = '0;
        end
    end

    // events, interrupt and break request
    always_comb begin
        ev = '0;
        ev[`DETT_I_MATCH] = hit;
        ev[`DETT_I_STOP] = (st_nxt == dett_pkg::ST_STOP) & (st_r != dett_pkg::ST_STOP);
        ev[`DETT_I_FULL] = (cnt_nxt == (IW+1)'(DEPTH)) & ~full;
        istat_nxt = istat_r;
        if (wr_en && paddr == `DETT_OFF_ISTAT) begin
            istat_nxt = istat_r & ~pwdata[`DETT_IRQ_W-1:0];
        end
        istat_nxt = istat_nxt | ev; // set beats a same-cycle clear
        irq_nxt = |(istat_r & imask_r);
        brk_nxt = (ctrl_r[`DETT_C_BKEV] & hit & prog_running)
            | (ctrl_r[`DETT_C_BKFULL] & ev[`DETT_I_FULL]);
    end

    // register writes
    always_comb begin
        ctrl_nxt = ctrl_r;
        evaddr_nxt = evaddr_r;
        amask_nxt = amask_r;
        evdata_nxt = evdata_r;
        dmask_nxt = dmask_r;
        imask_nxt = imask_r;
        idx_nxt = idx_r;
        if (wr_en) begin
            case (paddr)
                `DETT_OFF_CTRL: ctrl_nxt = pwdata[`DETT_CTRL_W-1:0];
                `DETT_OFF_EVADDR: evaddr_nxt = pwdata[AW-1:0];
                `DETT_OFF_AMASK: amask_nxt = pwdata[`DETT_AMW-1:0];
                `DETT_OFF_EVDATA: evdata_nxt = pwdata[DW-1:0];
                `DETT_OFF_DMASK: dmask_nxt = pwdata[DW-1:0];
                `DETT_OFF_IMASK: imask_nxt = pwdata[`DETT_IRQ_W-1:0];
                `DETT_OFF_INDEX: idx_nxt = pwdata[IW:0];
                default: ;
            endcase
        end
    end

    // read mux; trace entries read zero until visible
    always_comb begin
        rd_val = '0;
        pslverr_nxt = 1'b0;
        case (paddr)
            `DETT_OFF_CTRL: rd_val = 32'(ctrl_r);
            `DETT_OFF_EVADDR: rd_val = 32'(evaddr_r);
            `DETT_OFF_AMASK: rd_val = 32'(amask_r);
            `DETT_OFF_EVDATA: rd_val = 32'(evdata_r);
            `DETT_OFF_DMASK: rd_val = 32'(dmask_r);
            `DETT_OFF_STATUS: begin
                rd_val[`DETT_S_RUN] = (st_r == dett_pkg::ST_RUN);
                rd_val[`DETT_S_STOP] = (st_r == dett_pkg::ST_STOP);
                rd_val[`DETT_S_VIS] = vis;
                rd_val[`DETT_S_FULL] = full;
                rd_val[`DETT_S_CNT +: IW+1] = cnt_r;
            end
            `DETT_OFF_ISTAT: rd_val = 32'(istat_r);
            `DETT_OFF_IMASK: rd_val = 32'(imask_r);
            `DETT_OFF_INDEX: rd_val = 32'(idx_r);
            `DETT_OFF_TADDR: begin
                if (ent_ok) begin
                    rd_val[AW-1:0] = m_addr[rloc];
                    rd_val[`DETT_T_IP +: AW] = m_ip[rloc];
                end
            end
            `DETT_OFF_TDATA: begin
                if (ent_ok) begin
                    rd_val[DW-1:0] = m_data[rloc];
                    rd_val[`DETT_T_TYPE] = m_type[rloc];
                    rd_val[`DETT_T_EMUL] = m_emul[rloc];
                end
            end
            `DETT_OFF_CMD: ;
            default: pslverr_nxt = psel & ~penable;
        endcase
        // answer one cycle after setup, data caught at setup
        pready_nxt = psel & ~penable;
        prdata_nxt = (psel & ~penable & ~pwrite) ? rd_val : prdata_r;
    end

    // register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `DETT_CTRL_RST;
            evaddr_r <= '0;
            amask_r <= '0;
            evdata_r <= '0;
            dmask_r <= '0;
            istat_r <= '0;
            imask_r <= '0;
            idx_r <= '0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            st_r <= dett_pkg::ST_IDLE;
            cnt_r <= '0;
            wp_r <= '0;
            run_q_r <= 1'b0;
            brk_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            evaddr_r <= evaddr_nxt;
            amask_r <= amask_nxt;
            evdata_r <= evdata_nxt;
            dmask_r <= dmask_nxt;
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            idx_r <= idx_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wp_r <= wp_nxt;
            run_q_r <= prog_running;
            brk_r <= brk_nxt;
            irq_r <= irq_nxt;
        end
    end

    // trace memory write; no reset so it maps onto ram
    always_ff @(posedge pclk) begin
        if (rec) begin
            if (ctrl_r[`DETT_C_DATA]) begin
                m_addr[wp_r] <= range_base;
                m_ip[wp_r] <= acc_ip;
                m_data[wp_r] <= acc_data;
                m_type[wp_r] <= acc_write;
                m_emul[wp_r] <= acc_emul;
            end else begin
                m_addr[wp_r] <= br_addr;
                m_ip[wp_r] <= br_addr;
                m_data[wp_r] <= '0;
                m_type[wp_r] <= br_dest;
                m_emul[wp_r] <= br_emul;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign break_req = brk_r;
    assign irq = irq_r;

    // checks
    a_arm_norec: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == dett_pkg::ST_ARMED && hit && !prog_go && !clr_cmd)
        |=> (st_r == dett_pkg::ST_RUN) && cnt_r == $past(cnt_r))
        else $error("trigger access was recorded");
    a_start_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == dett_pkg::ST_RUN && start_hit && !clr_cmd && !prog_go)
        |=> st_r == dett_pkg::ST_RUN)
        else $error("stop taken despite start");
    a_vis_halt: assert property (@(posedge pclk) disable iff (!presetn)
        (prog_running && psel && !penable && !pwrite && paddr == `DETT_OFF_TDATA)
        |=> prdata == '0)
        else $error("trace visible while running");
    a_both_masks: assert property (@(posedge pclk) disable iff (!presetn)
        (amask_r != '0 && dmask_r[7:0] != 8'h00 && dmask_r[7:0] != 8'hFF) |-> !hit)
        else $error("match with both masks");
    a_size_word: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r[`DETT_C_SZ] == `DETT_SZ_WORD && !acc_word) |-> !hit)
        else $error("byte access matched word event");
    a_type_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r[`DETT_C_TY] == `DETT_TY_RD && acc_write) |-> !hit)
        else $error("write matched read event");
    a_newest_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (rec && !prog_go && !clr_cmd && st_nxt == dett_pkg::ST_RUN && idx_r == '0)
        |=> rloc == $past(wp_r))
        else $error("index zero is not newest");
    a_branch_nodata: assert property (@(posedge pclk) disable iff (!presetn)
        (rec && !ctrl_r[`DETT_C_DATA]) |=> m_data[$past(wp_r)] == '0)
        else $error("branch entry holds data");
    a_data_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (rec && ctrl_r[`DETT_C_DATA]) |=> m_data[$past(wp_r)] == $past(acc_data))
        else $error("data entry value wrong");
    a_byte_odd: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r[`DETT_C_EN] && ctrl_r[`DETT_C_SZ] == `DETT_SZ_BYTE
        && ctrl_r[`DETT_C_TY] == `DETT_TY_RW && dmask_r == '0 && amask_r == '0
        && acc_valid && !acc_word && acc_addr == evaddr_r) |-> hit)
        else $error("byte access missed");
    c_full: cover property (@(posedge pclk) disable iff (!presetn) full);
    c_stop_vis: cover property (@(posedge pclk) disable iff (!presetn) $rose(vis));
    c_armed_run: cover property (@(posedge pclk) disable iff (!presetn)
        st_r == dett_pkg::ST_ARMED ##1 st_r == dett_pkg::ST_RUN);
endmodule

// [sim/dett_core_model.sv]
// Purpose: behavioural target core that strobes data accesses and branches
// Assumes: one pclk domain, every strobe lasts one cycle
// Notes: released address, data and ip lines show inverted values so a stale value never matches
`timescale 1ns/1ps
module dett_core_model #(parameter int AW = 16, parameter int DW = 16) (
    // clock
    input wire logic pclk,
    // data accesses
    output logic acc_valid,
    output logic [AW-1:0] acc_addr,
    output logic [DW-1:0] acc_data,
    output logic acc_word,
    output logic acc_write,
    output logic [AW-1:0] acc_ip,
    output logic acc_emul,
    // branches
    output logic br_valid,
    output logic br_dest,
    output logic [AW-1:0] br_addr,
    output logic br_emul,
    // program control
    output logic prog_go,
    output logic prog_running
);
    // quiet start, program halted
    initial begin
        {acc_valid, br_valid, prog_go, prog_running} = 4'h0;
        {acc_addr, acc_data, acc_ip, br_addr} = '0;
        {acc_word, acc_write, acc_emul, br_dest, br_emul} = 5'h0;
    end
    // one data access; the ip is a fixed offset from the address
    task automatic acc(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic w,
        input logic wr, input logic em);
        @(posedge pclk);
        acc_valid <= 1'h1;
        {acc_addr, acc_data, acc_word, acc_write, acc_emul} <= {a, d, w, wr, em};
        acc_ip <= a + AW'(16'h0100);
        @(posedge pclk);
        acc_valid <= 1'h0;
        {acc_addr, acc_data, acc_ip} <= ~{a, d, a + AW'(16'h0100)};
    endtask
    // one branch record, source or destination
    task automatic br(input logic dst, input logic [AW-1:0] a, input logic em);
        @(posedge pclk);
        br_valid <= 1'h1;
        {br_dest, br_addr, br_emul} <= {dst, a, em};
        @(posedge pclk);
        br_valid <= 1'h0;
        br_addr <= ~a;
    endtask
    // launch pulse, then the program keeps running
    task automatic go();
        @(posedge pclk);
        prog_go <= 1'h1;
        prog_running <= 1'h1;
        @(posedge pclk);
        prog_go <= 1'h0;
    endtask
    // the falling edge of running is the break
    task automatic halt();
        @(posedge pclk);
        prog_running <= 1'h0;
    endtask
endmodule

// [sim/debug_event_trace_unit_test.sv]
// Purpose: self-checking bench for the event comparator and trace recorder
// Assumes: depth cut to 4 so a full trace comes quickly
// Notes: apb answers are taken at the rising edge that sees pready high
`timescale 1ns/1ps
`include "dett_map.svh"
module debug_event_trace_unit_test;
    localparam int DEPTH = 4;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, break_req, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, im;
    logic acc_valid, acc_word, acc_write, acc_emul, br_valid, br_dest, br_emul;
    logic prog_go, prog_running;
    logic [15:0] acc_addr, acc_data, acc_ip, br_addr;
    int bad_count = 0;
    int tests_run = 0;
    int brk_seen = 0;
    dett_top #(.DEPTH(DEPTH)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_data(acc_data), .acc_word(acc_word), .acc_write(acc_write), .acc_ip(acc_ip),
        .acc_emul(acc_emul), .br_valid(br_valid), .br_dest(br_dest), .br_addr(br_addr),
        .br_emul(br_emul), .prog_go(prog_go), .prog_running(prog_running),
        .break_req(break_req), .irq(irq));
    dett_core_model i_core (.pclk(pclk), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_data(acc_data), .acc_word(acc_word), .acc_write(acc_write), .acc_ip(acc_ip),
        .acc_emul(acc_emul), .br_valid(br_valid), .br_dest(br_dest), .br_addr(br_addr),
        .br_emul(br_emul), .prog_go(prog_go), .prog_running(prog_running));
    // 50 MHz clock
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    // count break pulses, each lasts one cycle
    always @(posedge pclk) begin
        if (break_req === 1'h1) begin
            brk_seen <= brk_seen + 1;
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            bad_count++;
            wrap_up();
        end
        // request held up to this edge, released only after it
        rdat = prdata;
        perr = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rdat & m, exp);
    endtask
    // reset values and an unmapped offset
    task automatic t_reset();
        rd(`DETT_OFF_CTRL, ALL, 32'h0);
        rd(`DETT_OFF_STATUS, ALL, 32'h0);
        rd(8'h30, ALL, 32'h0);
        chk({31'h0, perr}, 32'h1);
    endtask
    // one comparator case: program, clear status, access, look at status and irq
    task automatic mrow(input logic [1:0] sz, input logic [1:0] ty, input logic [15:0] ev,
        input logic [15:0] a, input logic w, input logic wrt, input logic exp);
        wr(`DETT_OFF_CTRL, 32'h1 | (32'(sz) << 1) | (32'(ty) << 3));
        wr(`DETT_OFF_EVADDR, {16'h0, ev});
        wr(`DETT_OFF_ISTAT, 32'h7);
        i_core.acc(a, 16'h0050, w, wrt, 1'h0);
        rd(`DETT_OFF_ISTAT, 32'h1, {31'h0, exp});
        chk({31'h0, irq}, {31'h0, exp & im[0]});
    endtask
    // size, type and mask cases; event addresses avoid vectors and branch targets
    task automatic t_match();
        im = 32'h1;
        wr(`DETT_OFF_IMASK, im);
        mrow(2'h1, 2'h1, 16'h0400, 16'h0400, 1'h0, 1'h0, 1'h1);
        mrow(2'h1, 2'h2, 16'h0401, 16'h0401, 1'h0, 1'h1, 1'h1);
        mrow(2'h2, 2'h1, 16'h0400, 16'h0400, 1'h1, 1'h0, 1'h1);
        mrow(2'h2, 2'h0, 16'h0400, 16'h0400, 1'h1, 1'h1, 1'h1);
        mrow(2'h1, 2'h0, 16'h0401, 16'h0401, 1'h1, 1'h0, 1'h1);
        mrow(2'h2, 2'h0, 16'h0400, 16'h0400, 1'h0, 1'h0, 1'h0);
        mrow(2'h1, 2'h0, 16'h0400, 16'h0400, 1'h1, 1'h1, 1'h0);
        mrow(2'h0, 2'h1, 16'h0400, 16'h0400, 1'h0, 1'h1, 1'h0);
        mrow(2'h0, 2'h2, 16'h0400, 16'h0400, 1'h0, 1'h0, 1'h0);
        mrow(2'h0, 2'h2, 16'h0400, 16'h0400, 1'h0, 1'h1, 1'h1);
        wr(`DETT_OFF_AMASK, 32'h1);
        mrow(2'h0, 2'h0, 16'h0400, 16'h0401, 1'h0, 1'h0, 1'h1);
        wr(`DETT_OFF_DMASK, 32'h000F);
        mrow(2'h0, 2'h0, 16'h0400, 16'h0401, 1'h0, 1'h0, 1'h0);
        wr(`DETT_OFF_AMASK, 32'h0);
        wr(`DETT_OFF_DMASK, 32'h0);
        im = 32'h0;
        wr(`DETT_OFF_IMASK, im);
        mrow(2'h0, 2'h0, 16'h0400, 16'h0400, 1'h0, 1'h0, 1'h1);
    endtask
    // data trace started by an event, stopped by break
    task automatic t_data();
        wr(`DETT_OFF_CMD, 32'h1);
        wr(`DETT_OFF_CTRL, 32'h061);
        wr(`DETT_OFF_EVADDR, 32'h0400);
        i_core.go();
        i_core.acc(16'h0400, 16'h0011, 1'h0, 1'h0, 1'h0);
        i_core.acc(16'h0400, 16'h00A5, 1'h0, 1'h1, 1'h1);
        i_core.acc(16'h0400, 16'h003C, 1'h0, 1'h0, 1'h0);
        i_core.acc(16'h0402, 16'h0077, 1'h0, 1'h0, 1'h0);
        rd(`DETT_OFF_STATUS, 32'h00070001, 32'h00020001);
        i_core.halt();
        rd(`DETT_OFF_STATUS, 32'h4, 32'h4);
        wr(`DETT_OFF_INDEX, 32'h0);
        rd(`DETT_OFF_TDATA, ALL, 32'h0000003C);
        rd(`DETT_OFF_TADDR, ALL, 32'h05000400);
        wr(`DETT_OFF_INDEX, 32'h1);
        rd(`DETT_OFF_TDATA, ALL, 32'h000300A5);
    endtask
    // start and stop on the same event: tracing must go on; break on every hit
    task automatic t_both();
        int b0;
        b0 = brk_seen;
        wr(`DETT_OFF_CMD, 32'h1);
        wr(`DETT_OFF_CTRL, 32'h361);
        i_core.go();
        repeat (3) i_core.acc(16'h0400, 16'h0050, 1'h0, 1'h1, 1'h0);
        rd(`DETT_OFF_STATUS, 32'h3, 32'h1);
        chk(32'(brk_seen - b0), 32'h3);
        i_core.halt();
    endtask
    // branch trace from launch to break
    task automatic t_branch();
        wr(`DETT_OFF_CMD, 32'h1);
        wr(`DETT_OFF_CTRL, 32'h0);
        i_core.go();
        i_core.br(1'h0, 16'h1234, 1'h0);
        i_core.br(1'h1, 16'h2000, 1'h1);
        i_core.halt();
        wr(`DETT_OFF_INDEX, 32'h0);
        rd(`DETT_OFF_TADDR, ALL, 32'h20002000);
        rd(`DETT_OFF_TDATA, ALL, 32'h00030000);
        wr(`DETT_OFF_INDEX, 32'h1);
        rd(`DETT_OFF_TADDR, ALL, 32'h12341234);
        rd(`DETT_OFF_TDATA, ALL, 32'h0);
    endtask
    // stop on full with break: trace hidden until the program halts
    task automatic t_full();
        int b0;
        b0 = brk_seen;
        wr(`DETT_OFF_CMD, 32'h1);
        wr(`DETT_OFF_CTRL, 32'h4A1);
        i_core.go();
        repeat (DEPTH + 1) i_core.acc(16'h0400, 16'h0050, 1'h0, 1'h0, 1'h0);
        rd(`DETT_OFF_STATUS, 32'h6, 32'h2);
        rd(`DETT_OFF_TDATA, ALL, 32'h0);
        chk(32'(brk_seen - b0), 32'h1);
        i_core.halt();
        rd(`DETT_OFF_STATUS, 32'h6, 32'h6);
    endtask
    // reset for 12 cycles, then the scenarios
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        im = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_match();
        t_data();
        t_both();
        t_branch();
        t_full();
        wrap_up();
    end
endmodule
